// [verilog/cte_unit.sv]
// Trap and system exception unit with an AHB-Lite register slave.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "cte_params.svh"

module cte_unit #(
    parameter int OPW = 16 // Op code width.
) (
    // Clock and reset.
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    // AHB-Lite slave.
    input  wire logic           i_hsel,
    input  wire logic [31:0]    i_haddr,
    input  wire logic [1:0]     i_htrans,
    input  wire logic           i_hwrite,
    input  wire logic [2:0]     i_hsize,
    input  wire logic [31:0]    i_hwdata,
    input  wire logic           i_hready,
    output logic      [31:0]    o_hrdata,
    output logic                o_hreadyout,
    output logic                o_hresp,
    // Instruction issue and op code checks.
    input  wire logic           i_instr_valid,
    input  wire logic [OPW-1:0] i_opcode,
    input  wire logic           i_opcode_undef,
    input  wire logic           i_priv_instr,
    // Vector state accesses of the issuing instruction.
    input  wire logic           i_vreg_access,
    input  wire logic           i_vlen_access,
    input  wire logic           i_vstride_access,
    input  wire logic           i_vmask_access,
    input  wire logic           i_vfirst_access,
    // Breakpoints.
    input  wire logic           i_bkpt,
    input  wire logic           i_pbkpt,
    // Memory reference, system call and return checks.
    input  wire logic           i_ref_valid,
    input  wire logic [2:0]     i_ref_ring,
    input  wire logic           i_sysc,
    input  wire logic [2:0]     i_sysc_ring,
    input  wire logic           i_sysc_gate_ok,
    input  wire logic           i_rtn,
    input  wire logic           i_rtn_ext,
    input  wire logic [2:0]     i_rtn_ring,
    input  wire logic           i_rtn_len_ok,
    // Fork pickup and concurrency frame pop.
    input  wire logic           i_fork_pickup,
    input  wire logic [31:0]    i_new_thread_status_word,
    input  wire logic [31:0]    i_new_thread_start_address,
    input  wire logic           i_ttc_frame_pop,
    input  wire logic [31:0]    i_popped_status_word,
    // Trap sequencing outputs.
    output logic                o_busy,
    output logic                o_frame_push,
    output logic      [1:0]     o_frame_length_code,
    output logic      [31:0]    o_saved_pc,
    output logic                o_trap_valid,
    output logic      [31:0]    o_trap_vector,
    output logic      [2:0]     o_trap_ring,
    output logic                o_machine_exc,
    output logic                o_exc_local,
    output logic      [31:0]    o_trap_class_register,
    // Execution mode outputs.
    output logic                o_overlap_disable,
    output logic                o_ordered_stores
);

    // Whole state of the unit in one record.
    typedef struct packed {
        cte_pkg::cte_state_t st;        // Sequencer state.
        logic [31:0]         ctrl;      // Status word held by software.
        logic [31:0]         sp0;       // Ring 0 stack pointer.
        logic [31:0]         tclass;    // Trap class register.
        logic [31:0]         tpc;       // Last saved program counter.
        logic [31:0]         rdata;     // Read data for the data phase.
        logic                wpend;     // A write data phase is due.
        logic [7:0]          waddr;     // Offset of the pending write.
        logic                psys;      // Pending event is a system one.
        logic                puseq;     // Pending event loads its class.
        logic [7:0]          pcls;      // Pending class code.
        logic [7:0]          pqual;     // Pending qualifier code.
        logic [31:0]         pvec;      // Pending handler pointer.
        logic [2:0]          pring;     // Pending target ring.
        logic                push;      // Frame push strobe.
        logic [1:0]          fcode;     // Frame length code.
        logic [31:0]         spc;       // Saved program counter.
        logic                trapv;     // Handler entry strobe.
        logic [31:0]         vec;       // Handler pointer address.
        logic [2:0]          tring;     // Ring the handler runs in.
        logic                mexc;      // Machine exception strobe.
        logic                local_x;   // System exception is local.
        logic                busy;      // Events are held off.
    } cte_state_rec_t;

    cte_state_rec_t s_r;   // Registered state.
    cte_state_rec_t s_nxt; // Next state.

    // Event decode of the issuing instruction.
    logic       vec_instr;   // Instruction touches vector state.
    logic       ev_err;      // All-zero op code.
    logic       ev_undef;    // Undefined op code.
    logic       ev_ringv;    // Any ring violation.
    logic [7:0] ringv_q;     // Qualifier of that violation.
    logic       ev_vv;       // Vector valid trap.
    logic       ev_tit;      // Thread initialization trap.
    logic [2:0] cur_ring;    // Ring now executing.
    logic       sys_bad;     // Ring 0 stack or page unusable.
    logic       idle;        // Sequencer can take an event.
    logic       a_phase;     // Bus address phase accepted.

    assign cur_ring = s_r.ctrl[`CTE_B_RING_HI:`CTE_B_RING_LO];
    assign idle     = (s_r.st == cte_pkg::CTE_IDLE);
    assign a_phase  = i_hsel && i_hready && i_htrans[1];

    // Classify the current instruction and pick a ring violation code.
    always_comb
    begin
        // Every vector-state register access counts as vector use.
        vec_instr = i_instr_valid && (i_vreg_access || i_vlen_access ||
                    i_vstride_access || i_vmask_access ||
                    i_vfirst_access);
        ev_err    = i_instr_valid && (i_opcode == '0);
        ev_undef  = i_instr_valid && i_opcode_undef;
        ev_vv     = vec_instr && !s_r.ctrl[`CTE_B_VV];
        // The fork block word decides, not our own status word.
        ev_tit    = i_fork_pickup &&
                    i_new_thread_status_word[`CTE_B_TIT];
        ev_ringv  = 1'b1;
        ringv_q   = `CTE_Q_NONE;
        // Lowest qualifier wins when several violations coincide.
        if (i_instr_valid && i_priv_instr && cur_ring != `CTE_RING0)
        begin
            ringv_q = `CTE_Q_PRIV;
        end
        else if (i_ref_valid && i_ref_ring < cur_ring)
        begin
            ringv_q = `CTE_Q_INADDR;
        end
        else if (i_sysc && i_sysc_ring > cur_ring)
        begin
            ringv_q = `CTE_Q_OUTSYSC;
        end
        else if (i_rtn && i_rtn_ext && i_rtn_ring < cur_ring)
        begin
            // Short and long returns never leave the ring.
            ringv_q = `CTE_Q_INRTN;
        end
        else if (i_sysc && !i_sysc_gate_ok)
        begin
            ringv_q = `CTE_Q_GATE;
        end
        else if (i_rtn && !i_rtn_len_ok)
        begin
            ringv_q = `CTE_Q_FRLEN;
        end
        else
        begin
            ev_ringv = 1'b0;
        end
    end

    // A system exception needs a word-aligned ring 0 stack and page 0.
    assign sys_bad = (s_r.sp0[1:0] != 2'h0) ||
                     !s_r.ctrl[`CTE_B_RES];

    // Next state: bus slave, status word and trap sequencer.
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.push    = 1'b0;
        s_nxt.trapv   = 1'b0;
        s_nxt.mexc    = 1'b0;
        s_nxt.wpend   = 1'b0;
        // Zero wait states: every transfer completes in its data phase.
        s_nxt.rdata   = `CTE_ZERO32;
        if (a_phase && !i_hwrite)
        begin
            unique case (i_haddr[7:0])
                `CTE_OFF_CTRL:   s_nxt.rdata = s_r.ctrl;
                `CTE_OFF_SP0:    s_nxt.rdata = s_r.sp0;
                `CTE_OFF_TCLASS: s_nxt.rdata = s_r.tclass;
                `CTE_OFF_TPC:    s_nxt.rdata = s_r.tpc;
                `CTE_OFF_TVEC:   s_nxt.rdata = s_r.vec;
                default:         s_nxt.rdata = `CTE_ZERO32;
            endcase
        end
        if (a_phase && i_hwrite)
        begin
            s_nxt.wpend = 1'b1;
            s_nxt.waddr = i_haddr[7:0];
        end
        // Software writes raise no exception in any ring.
        if (s_r.wpend && s_r.waddr == `CTE_OFF_CTRL)
        begin
            s_nxt.ctrl = i_hwdata;
        end
        if (s_r.wpend && s_r.waddr == `CTE_OFF_SP0)
        begin
            s_nxt.sp0 = i_hwdata;
        end
        // Popping the frame reloads the saved word, so the trace bit
        // comes back; it overrides a software write in the same cycle.
        if (i_ttc_frame_pop)
        begin
            s_nxt.ctrl = i_popped_status_word;
        end
        unique case (s_r.st)
            cte_pkg::CTE_IDLE:
            begin
                s_nxt.busy = 1'b0;
                s_nxt.psys = 1'b1;
                s_nxt.puseq = 1'b1;
                s_nxt.pqual = `CTE_Q_NONE;
                s_nxt.pring = `CTE_RING0;
                s_nxt.fcode = `CTE_FRL_EXT;
                s_nxt.spc   = i_new_thread_start_address;
                s_nxt.pvec  = `CTE_VEC_SYSEXC;
                s_nxt.pcls  = `CTE_CL_ERREXIT;
                s_nxt.st    = cte_pkg::CTE_PUSH;
                // Priority runs from op code errors down to trace.
                if (ev_err)
                begin
                    s_nxt.pcls = `CTE_CL_ERREXIT;
                end
                else if (ev_undef)
                begin
                    s_nxt.pcls = `CTE_CL_UNDEF;
                end
                else if (ev_ringv)
                begin
                    s_nxt.pcls  = `CTE_CL_RINGV;
                    s_nxt.pqual = ringv_q;
                    // An inward reference is a fault: full context.
                    if (ringv_q == `CTE_Q_INADDR)
                    begin
                        s_nxt.fcode = `CTE_FRL_CTX;
                    end
                end
                else if (ev_vv)
                begin
                    s_nxt.pcls = `CTE_CL_VV;
                    s_nxt.pvec = `CTE_VEC_VV;
                end
                else if (i_pbkpt)
                begin
                    s_nxt.pcls = `CTE_CL_PBKPT;
                end
                else if (i_bkpt)
                begin
                    // User trap: current ring, no class load.
                    s_nxt.psys  = 1'b0;
                    s_nxt.puseq = 1'b0;
                    s_nxt.pring = cur_ring;
                    s_nxt.pvec  = `CTE_VEC_BKPT;
                end
                else if (ev_tit)
                begin
                    // Lowest of all: trace trap in the same ring.
                    s_nxt.psys = 1'b0;
                    s_nxt.pring = cur_ring;
                    s_nxt.pcls = `CTE_CL_TIT;
                    s_nxt.pvec = `CTE_VEC_TRACE;
                end
                else
                begin
                    s_nxt.st = cte_pkg::CTE_IDLE;
                end
                if (s_nxt.st == cte_pkg::CTE_PUSH)
                begin
                    s_nxt.busy = 1'b1;
                    // Fork traps save the new thread start address.
                    if (!(ev_tit && !ev_err && !ev_undef && !ev_ringv &&
                          !ev_vv && !i_pbkpt && !i_bkpt))
                    begin
                        s_nxt.spc = s_r.tpc;
                    end
                end
            end
            cte_pkg::CTE_PUSH:
            begin
                // System exceptions cannot be masked; a bad ring 0
                // turns them into a machine exception instead.
                if (s_r.psys && sys_bad)
                begin
                    s_nxt.mexc  = 1'b1;
                    s_nxt.vec   = `CTE_VEC_MACH;
                    s_nxt.tring = `CTE_RING0;
                    s_nxt.st    = cte_pkg::CTE_IDLE;
                    s_nxt.busy  = 1'b0;
                end
                else
                begin
                    s_nxt.push = 1'b1;
                    s_nxt.tpc  = s_r.spc;
                    s_nxt.st   = cte_pkg::CTE_JUMP;
                end
            end
            cte_pkg::CTE_JUMP:
            begin
                // Class and qualifier land after the frame is pushed.
                if (s_r.puseq)
                begin
                    s_nxt.tclass = {s_r.pqual, s_r.pcls,
                                    16'h0000};
                end
                s_nxt.trapv   = 1'b1;
                s_nxt.vec     = s_r.pvec;
                s_nxt.tring   = s_r.pring;
                s_nxt.local_x = s_r.psys;
                s_nxt.ctrl[`CTE_B_RING_HI:`CTE_B_RING_LO] = s_r.pring;
                s_nxt.st      = cte_pkg::CTE_IDLE;
                s_nxt.busy    = 1'b0;
            end
            default:
            begin
                s_nxt.st   = cte_pkg::CTE_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    // Register the state; the reset is synchronous.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            s_r      <= '0;
            s_r.st   <= cte_pkg::CTE_IDLE;
            s_r.ctrl <= `CTE_CTRL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from state flops, except the tied-off ready and response.
    assign o_hrdata              = s_r.rdata;
    assign o_hreadyout           = 1'b1;
    assign o_hresp               = 1'b0;
    assign o_busy                = s_r.busy;
    assign o_frame_push          = s_r.push;
    assign o_frame_length_code   = s_r.fcode;
    assign o_saved_pc            = s_r.tpc;
    assign o_trap_valid          = s_r.trapv;
    assign o_trap_vector         = s_r.vec;
    assign o_trap_ring           = s_r.tring;
    assign o_machine_exc         = s_r.mexc;
    assign o_exc_local           = s_r.local_x;
    assign o_trap_class_register = s_r.tclass;
    // Pipeline overlap and store order only; results never change.
    assign o_overlap_disable     = s_r.ctrl[`CTE_B_SERIAL];
    assign o_ordered_stores      = s_r.ctrl[`CTE_B_ORDERED];

    // Checks on the sequencer.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic only_tit; // Fork trap with nothing above it.
    assign only_tit = idle && ev_tit && !ev_err && !ev_undef &&
                      !ev_ringv && !ev_vv && !i_pbkpt && !i_bkpt;

    // Two steps of every accepted trap.
    sequence push_then_jump;
        o_frame_push ##1 o_trap_valid;
    endsequence

    tit_entry_a: assert property (only_tit |=> ##1 push_then_jump ##0
        (o_trap_vector == `CTE_VEC_TRACE) && o_trap_class_register ==
        {`CTE_Q_NONE, `CTE_CL_TIT, 16'h0000})
        else $error("init trap not taken");
    tit_ring_a: assert property (only_tit ##3 o_trap_valid
        |-> o_trap_ring == $past(cur_ring, 3))
        else $error("init trap changed ring");
    tit_pc_a: assert property (only_tit |=> ##1 o_frame_push
        && o_saved_pc == $past(i_new_thread_start_address, 2))
        else $error("init trap saved pc wrong");
    undef_class_a: assert property (idle && ev_undef && !ev_err
        && !sys_bad |=> ##2 o_trap_class_register[31:16] ==
        {`CTE_Q_NONE, `CTE_CL_UNDEF})
        else $error("undefined op class wrong");
    err_vec_a: assert property (idle && ev_err && !sys_bad
        |=> ##1 push_then_jump ##0 o_trap_vector == `CTE_VEC_SYSEXC)
        else $error("error exit vector wrong");
    vv_vec_a: assert property (idle && ev_vv && !ev_err && !ev_undef
        && !ev_ringv && !sys_bad |=> ##1 push_then_jump ##0
        (o_trap_vector == `CTE_VEC_VV && o_trap_ring == `CTE_RING0))
        else $error("vector trap wrong");
    vv_quiet_a: assert property (idle && vec_instr
        && s_r.ctrl[`CTE_B_VV] && !ev_err && !ev_undef && !ev_ringv
        && !i_pbkpt && !i_bkpt && !i_fork_pickup |=> !o_busy)
        else $error("vector trap with flag set");
    mach_exc_a: assert property (idle && (ev_err || ev_undef)
        && sys_bad |=> ##1 o_machine_exc && !o_frame_push)
        else $error("machine exception missing");
    ring_qual_a: assert property (idle && ev_ringv && !ev_err
        && !ev_undef && !sys_bad |=> ##2 o_trap_valid &&
        o_trap_class_register[31:24] == $past(ringv_q, 3))
        else $error("ring qualifier wrong");
    ttc_pop_a: assert property (i_ttc_frame_pop |=>
        s_r.ctrl[`CTE_B_TTC] == $past(i_popped_status_word[`CTE_B_TTC]))
        else $error("trace bit not restored");

endmodule : cte_unit

// [shared/cte_params.svh]
// Constants for the trap and system exception unit.
`ifndef CTE_PARAMS_SVH
`define CTE_PARAMS_SVH
// Register byte offsets on the bus.
`define CTE_OFF_CTRL      8'h00
`define CTE_OFF_SP0       8'h04
`define CTE_OFF_TCLASS    8'h08
`define CTE_OFF_TPC       8'h0C
`define CTE_OFF_TVEC      8'h10
// Control register field positions.
`define CTE_B_SERIAL      0
`define CTE_B_ORDERED     1
`define CTE_B_TTC         2
`define CTE_B_TIT         3
`define CTE_B_VV          4
`define CTE_B_RES         5
`define CTE_B_RING_LO     8
`define CTE_B_RING_HI     10
// Handler pointer addresses in page 0.
`define CTE_VEC_SYSEXC    32'h0000_000C
`define CTE_VEC_VV        32'h0000_001C
`define CTE_VEC_TRACE     32'h0000_0040
`define CTE_VEC_BKPT      32'h0000_0050
`define CTE_VEC_MACH      32'h0000_0000
// Class and qualifier codes.
`define CTE_CL_ERREXIT    8'h00
`define CTE_CL_UNDEF      8'h01
`define CTE_CL_RINGV      8'h02
`define CTE_CL_VV         8'h03
`define CTE_CL_PBKPT      8'h05
`define CTE_CL_TIT        8'h08
`define CTE_Q_NONE        8'h00
`define CTE_Q_PRIV        8'h00
`define CTE_Q_INADDR      8'h01
`define CTE_Q_OUTSYSC     8'h02
`define CTE_Q_INRTN       8'h03
`define CTE_Q_GATE        8'h04
`define CTE_Q_FRLEN       8'h05
// Frame length codes and rings.
`define CTE_FRL_EXT       2'h1
`define CTE_FRL_CTX       2'h0
`define CTE_RING0         3'h0
`define CTE_RING_USER     3'h4
// Reset values.
`define CTE_CTRL_RST      32'h0000_0420
`define CTE_ZERO32        32'h0000_0000
`endif

// [shared/cte_pkg.sv]
// Types shared by the trap and system exception unit.
package cte_pkg;
    // Sequencer states, Gray coded along idle, push, jump.
    typedef enum logic [1:0]
    {
        CTE_IDLE = 2'h0,
        CTE_PUSH = 2'h1,
        CTE_JUMP = 2'h3
    } cte_state_t;
endpackage : cte_pkg

// [verif/tb.sv]
// Self-checking testbench for the trap and system exception unit.
`timescale 1ns/1ns
`include "cte_params.svh"
module tb;
    // Clock, reset and AHB-Lite master signals.
    logic        i_clk = 0, i_rstn = 0, i_hsel, i_hwrite;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic        o_hreadyout, o_hresp;
    wire logic   i_hready = o_hreadyout; // One slave, so its ready is hready.
    // Pipeline event inputs.
    logic        i_instr_valid, i_opcode_undef, i_priv_instr, i_bkpt, i_pbkpt;
    logic [15:0] i_opcode;
    logic        i_vreg_access, i_vlen_access, i_vstride_access;
    logic        i_vmask_access, i_vfirst_access, i_ref_valid, i_sysc;
    logic [2:0]  i_ref_ring, i_sysc_ring, i_rtn_ring, o_trap_ring;
    logic        i_sysc_gate_ok, i_rtn, i_rtn_ext, i_rtn_len_ok;
    logic        i_fork_pickup, i_ttc_frame_pop;
    logic [31:0] i_new_thread_status_word, i_new_thread_start_address;
    logic [31:0] i_popped_status_word, o_saved_pc, o_trap_vector;
    logic [31:0] o_trap_class_register, rd;
    // Trap and mode outputs.
    logic        o_busy, o_frame_push, o_trap_valid, o_machine_exc;
    logic        o_exc_local, o_overlap_disable, o_ordered_stores;
    logic [1:0]  o_frame_length_code;
    int          num_errors = 0, check_count = 0;

    cte_unit #(.OPW(16)) dut_u (.*);

    // Free-running 100 MHz clock.
    always #5 i_clk = ~i_clk;

    // Compares one result; case inequality keeps unknowns from matching.
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // One single-word AHB-Lite transfer; only the watchdog ends a wait.
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        i_hsel   <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr  <= {24'h0, a};
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata; // Read data is taken at the data-phase edge.
        i_hsel <= 1'b0;
    endtask : ahb

    // Returns every event input to quiet values.
    task quiet();
        i_instr_valid <= 0; i_opcode <= 16'h1234; i_opcode_undef <= 0;
        i_priv_instr <= 0; i_bkpt <= 0; i_pbkpt <= 0; i_ref_valid <= 0;
        i_vreg_access <= 0; i_vlen_access <= 0; i_vstride_access <= 0;
        i_vmask_access <= 0; i_vfirst_access <= 0; i_ref_ring <= 3'h4;
        i_sysc <= 0; i_sysc_ring <= 3'h4; i_sysc_gate_ok <= 1; i_rtn <= 0;
        i_rtn_ext <= 0; i_rtn_ring <= 3'h4; i_rtn_len_ok <= 1;
        i_fork_pickup <= 0; i_ttc_frame_pop <= 0;
    endtask : quiet

    // Presents one event for a single cycle; the current ring is 4.
    task fire(input int k);
        @(posedge i_clk);
        case (k)
            0: begin i_instr_valid <= 1; i_opcode <= 16'h0000; end
            1: begin i_instr_valid <= 1; i_opcode_undef <= 1; end
            2: begin i_instr_valid <= 1; i_priv_instr <= 1; end
            3: begin i_ref_valid <= 1; i_ref_ring <= 3'h0; end
            4: begin i_sysc <= 1; i_sysc_ring <= 3'h5; end
            5: begin i_rtn <= 1; i_rtn_ext <= 1; i_rtn_ring <= 3'h2; end
            6: begin i_sysc <= 1; i_sysc_gate_ok <= 0; end
            7: begin i_rtn <= 1; i_rtn_ext <= 1; i_rtn_len_ok <= 0; end
            8: begin i_instr_valid <= 1; i_vreg_access <= 1; end
            9: begin i_instr_valid <= 1; i_vlen_access <= 1; end
            10: begin i_instr_valid <= 1; i_vstride_access <= 1; end
            11: begin i_instr_valid <= 1; i_vmask_access <= 1; end
            12: begin i_instr_valid <= 1; i_vfirst_access <= 1; end
            13: i_pbkpt <= 1;
            14: i_bkpt <= 1;
            15: i_fork_pickup <= 1;
            default: i_ttc_frame_pop <= 1;
        endcase
        @(posedge i_clk);
        quiet();
    endtask : fire

    // Follows busy, then the push and the jump of a trap just taken.
    task trap(input logic [31:0] v, input logic [2:0] r, input logic [31:0] c,
              input logic [1:0] frame_length_code);
        #1;
        chk(o_busy, 1, "busy");
        @(posedge i_clk);
        #1;
        chk(o_frame_push, 1, "push");
        chk(o_frame_length_code, frame_length_code, "frame code");
        @(posedge i_clk);
        #1;
        chk(o_trap_valid, 1, "enter");
        chk(o_trap_vector, v, "vector");
        chk(o_trap_ring, r, "ring");
        chk(o_trap_class_register, c, "class");
        chk(o_exc_local, r == 3'h0, "local");
        chk(o_busy, 0, "done");
    endtask : trap

    // Checks that an event was let through without any trap.
    task no_trap();
        #1;
        chk(o_busy, 0, "no busy");
        @(posedge i_clk);
        #1;
        chk(o_frame_push | o_machine_exc, 0, "no push");
        @(posedge i_clk);
        #1;
        chk(o_trap_valid, 0, "no entry");
    endtask : no_trap

    // Prints the counts and the verdict, then ends the run.
    task tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short; the tests need far fewer cycles than this.
    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial
    begin
        i_hsel = 0; i_htrans = 0; i_hwrite = 0; i_haddr = 0; i_hwdata = 0;
        i_hsize = 3'h2; i_new_thread_status_word = 0;
        i_new_thread_start_address = 0; i_popped_status_word = 0;
        quiet();
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        ahb(0, `CTE_OFF_CTRL, 0);
        chk(rd, `CTE_CTRL_RST, "ctrl reset");
        ahb(0, 8'h20, 0);
        chk(rd, 0, "unmapped");
        chk(o_hresp, 0, "okay");
        fire(0); trap(`CTE_VEC_SYSEXC, 0, 0, 1);
        ahb(1, `CTE_OFF_CTRL, `CTE_CTRL_RST);
        fire(1); trap(`CTE_VEC_SYSEXC, 0, 32'h0001_0000, 1);
        // Each qualifier from a fresh ring 4; inward references push context.
        for (int q = 0; q < 6; q++)
        begin
            ahb(1, `CTE_OFF_CTRL, `CTE_CTRL_RST);
            fire(2 + q);
            // Inward references push a context frame, all else extended.
            trap(`CTE_VEC_SYSEXC, 0, {q[7:0], 24'h02_0000},
                 q != 1);
        end
        // Every kind of vector state access counts while the flag is clear.
        for (int k = 8; k < 13; k++)
        begin
            ahb(1, `CTE_OFF_CTRL, `CTE_CTRL_RST);
            fire(k); trap(`CTE_VEC_VV, 0, 32'h0003_0000, 1);
        end
        ahb(1, `CTE_OFF_CTRL, 32'h0000_0430);
        fire(8); no_trap();
        ahb(1, `CTE_OFF_CTRL, `CTE_CTRL_RST);
        fire(13); trap(`CTE_VEC_SYSEXC, 0, 32'h0005_0000, 1);
        ahb(1, `CTE_OFF_CTRL, `CTE_CTRL_RST);
        fire(14); trap(`CTE_VEC_BKPT, 4, 32'h0005_0000, 1);
        // Fork decision follows the fork block, not the local control bits.
        ahb(1, `CTE_OFF_CTRL, 32'h0000_0429);
        i_new_thread_status_word <= 32'h0000_0000;
        fire(15); no_trap();
        ahb(1, `CTE_OFF_CTRL, 32'h0000_0421);
        i_new_thread_status_word <= 32'h0000_0008;
        i_new_thread_start_address <= 32'h0000_8A40;
        fire(15);
        trap(`CTE_VEC_TRACE, 4, 32'h0008_0000, 1);
        chk(o_saved_pc, 32'h0000_8A40, "thread pc");
        // Misaligned ring 0 stack turns the exception into a machine one.
        ahb(1, `CTE_OFF_SP0, 32'h0000_0002);
        fire(1);
        @(posedge i_clk);
        #1;
        chk(o_machine_exc, 1, "machine");
        chk(o_frame_push, 0, "machine push");
        ahb(1, `CTE_OFF_SP0, 0);
        ahb(1, `CTE_OFF_CTRL, 32'h0000_0423);
        repeat (2) @(posedge i_clk);
        #1;
        chk(o_overlap_disable, 1, "serial");
        chk(o_ordered_stores, 1, "ordered");
        chk(o_busy, 0, "mode busy");
        i_popped_status_word <= 32'h0000_0424;
        fire(16);
        ahb(0, `CTE_OFF_CTRL, 0);
        chk(rd, 32'h0000_0424, "pop");
        tally_and_finish();
    end
endmodule : tb
